//--- verilog/qugc_pkg.sv
// Shared constants and types for the quad UART global control bank.
// Assumes a single device clock domain and an 8-bit host register bus.
package qugc_pkg;

  // Register byte addresses inside the configuration block
  localparam logic [7:0] QUGC_BLOCK_BASE   = 8'h80;
  localparam logic [3:0] QUGC_BLOCK_TAG    = 4'h8;
  localparam logic [7:0] QUGC_ADR_PENDING  = 8'h80;
  localparam logic [7:0] QUGC_ADR_SRC_LOW  = 8'h81;
  localparam logic [7:0] QUGC_ADR_SRC_HIGH = 8'h82;
  localparam logic [7:0] QUGC_ADR_SRC_SPR  = 8'h83;
  localparam logic [7:0] QUGC_ADR_CNT_CTL  = 8'h84;
  localparam logic [7:0] QUGC_ADR_CNT_SPR  = 8'h85;
  localparam logic [7:0] QUGC_ADR_PRE_LOW  = 8'h86;
  localparam logic [7:0] QUGC_ADR_PRE_HIGH = 8'h87;
  localparam logic [7:0] QUGC_ADR_SAMPLING = 8'h88;
  localparam logic [7:0] QUGC_ADR_AUX_SPR  = 8'h89;
  localparam logic [7:0] QUGC_ADR_CH_RESET = 8'h8a;

  // Count control field positions
  localparam int QUGC_CTL_INT_EN = 0;
  localparam int QUGC_CTL_START  = 1;
  localparam int QUGC_CTL_ONESHOT = 2;
  localparam int QUGC_CTL_EXT_CLK = 3;
  localparam logic [7:0] QUGC_CTL_WMASK = 8'h0f;

  // Values after reset
  localparam logic [7:0]  QUGC_RST_BYTE  = 8'h00;
  localparam logic [15:0] QUGC_RST_COUNT = 16'h0000;

  // Source codes, one per priority level
  localparam logic [2:0] QUGC_CODE_NONE    = 3'h0;
  localparam logic [2:0] QUGC_CODE_RX      = 3'h1;
  localparam logic [2:0] QUGC_CODE_RX_TOUT = 3'h2;
  localparam logic [2:0] QUGC_CODE_TX      = 3'h3;
  localparam logic [2:0] QUGC_CODE_MODEM   = 3'h4;
  localparam logic [2:0] QUGC_CODE_TIMER   = 3'h7;

  localparam int QUGC_CHANNELS = 4;

  // Interrupt source levels reported by one UART channel
  typedef struct packed {
    logic rx_data_available; // Receive FIFO at or above trigger
    logic line_error;        // Any receive line error flag
    logic rx_timeout;        // Receive time-out, held until FIFO empty
    logic tx_space_available; // Holding or shift register empty
    logic modem_delta;       // Modem or flow-control line change
    logic char_detect;       // Xon/Xoff or special character seen
  } qugc_src_t;

  // Host register bus request
  typedef struct packed {
    logic       sel;
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } qugc_bus_t;

endpackage

//--- verilog/qugc_global_control.sv
// Global configuration bank of a four-channel UART: pending flags, source
// codes, 16-bit down timer, sampling select and per-channel soft reset.
// Assumes host bus strobes are synchronous to clk_i; the external count
// clock pin is asynchronous and must run slower than half of clk_i.
`timescale 1ns/1ns

module qugc_global_control
  import qugc_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  // Host register bus
  input  wire qugc_bus_t                bus_i,
  output logic      [7:0]               rdata_o,
  output logic                          rdata_valid_o,
  // Channel interrupt sources
  input  wire qugc_src_t [QUGC_CHANNELS-1:0] chan_src_i,
  // External count clock pin
  input  wire logic                     external_count_clock_pin_i,
  // Channel controls and status
  output logic      [QUGC_CHANNELS-1:0] channel_pending_o,
  output logic      [QUGC_CHANNELS-1:0] sampling_8x_o,
  output logic      [QUGC_CHANNELS-1:0] channel_soft_reset_o,
  output logic                          count_timeout_o
);

  typedef enum logic {QUGC_T_IDLE, QUGC_T_RUN} qugc_tstate_t;

  logic [7:0]        count_control;
  logic [7:0]        count_preset_low;
  logic [7:0]        count_preset_high;
  logic [7:0]        sampling_rate_select;
  logic [15:0]       count_value;
  logic              timeout_flag;
  logic [2:0]        code [QUGC_CHANNELS];
  logic [2:0]        next_code [QUGC_CHANNELS];
  logic              ext_sync1;
  logic              ext_sync2;
  logic              ext_prev;
  logic              tick;
  logic              hit_zero;
  logic              start_write;
  logic              in_block;
  logic              rd_hit;
  logic              wr_hit;
  logic              ctl_read;
  logic [7:0]        next_rdata;
  qugc_tstate_t      tstate;

  // Priority encoder for one channel; the timer only reaches channel 0
  function automatic logic [2:0] src_code(input qugc_src_t s, input logic tmr);
    logic [2:0] c;
    c = QUGC_CODE_NONE;
    if (s.rx_data_available || s.line_error)
      c = QUGC_CODE_RX;
    else if (s.rx_timeout)
      c = QUGC_CODE_RX_TOUT;
    else if (s.tx_space_available)
      c = QUGC_CODE_TX;
    else if (s.modem_delta || s.char_detect)
      c = QUGC_CODE_MODEM;
    else if (tmr)
      c = QUGC_CODE_TIMER;
    return c;
  endfunction

  // Address decode inside the upper configuration block
  assign in_block    = bus_i.sel && (bus_i.addr[7:4] == QUGC_BLOCK_TAG);
  assign rd_hit      = in_block && bus_i.rd;
  assign wr_hit      = in_block && bus_i.wr;
  assign ctl_read    = rd_hit && (bus_i.addr == QUGC_ADR_CNT_CTL);
  assign start_write = wr_hit && (bus_i.addr == QUGC_ADR_CNT_CTL) && bus_i.wdata[QUGC_CTL_START];

  // Codes per channel; only channel 0 sees the enabled timer
  always_comb
  begin
    for (int i = 0; i < QUGC_CHANNELS; i++)
    begin
      next_code[i] = src_code(chan_src_i[i],
                              (i == 0) && timeout_flag && count_control[QUGC_CTL_INT_EN]);
    end
  end

  // Registered codes and pending flags
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < QUGC_CHANNELS; i++)
    begin
      if (!reset_n_i)
      begin
        code[i]              <= QUGC_CODE_NONE;
        channel_pending_o[i] <= 1'b0;
      end
      else
      begin
        code[i]              <= next_code[i];
        channel_pending_o[i] <= (next_code[i] != QUGC_CODE_NONE);
      end
    end
  end

  // Read mux; reserved and write-only locations return zero
  always_comb
  begin
    next_rdata = QUGC_RST_BYTE;
    case (bus_i.addr)
      QUGC_ADR_PENDING:  next_rdata = {4'h0, channel_pending_o};
      QUGC_ADR_SRC_LOW:  next_rdata = {code[2][1:0], code[1], code[0]};
      QUGC_ADR_SRC_HIGH: next_rdata = {4'h0, code[3], code[2][2]};
      QUGC_ADR_CNT_CTL:  next_rdata = count_control;
      QUGC_ADR_PRE_LOW:  next_rdata = count_preset_low;
      QUGC_ADR_PRE_HIGH: next_rdata = count_preset_high;
      QUGC_ADR_SAMPLING: next_rdata = sampling_rate_select;
      QUGC_ADR_CNT_SPR:  next_rdata = QUGC_RST_BYTE;
      QUGC_ADR_AUX_SPR:  next_rdata = QUGC_RST_BYTE;
      default:           next_rdata = QUGC_RST_BYTE;
    endcase
  end

  // Read data register, one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      rdata_o       <= QUGC_RST_BYTE;
      rdata_valid_o <= 1'b0;
    end
    else
    begin
      rdata_valid_o <= rd_hit;
      if (rd_hit)
        rdata_o <= next_rdata;
    end
  end

  // Writable configuration; reserved control bits never store
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      count_control        <= QUGC_RST_BYTE;
      count_preset_low     <= QUGC_RST_BYTE;
      count_preset_high    <= QUGC_RST_BYTE;
      sampling_rate_select <= QUGC_RST_BYTE;
    end
    else if (wr_hit)
    begin
      case (bus_i.addr)
        QUGC_ADR_CNT_CTL:  count_control <= bus_i.wdata & QUGC_CTL_WMASK;
        QUGC_ADR_PRE_LOW:  count_preset_low <= bus_i.wdata;
        QUGC_ADR_PRE_HIGH: count_preset_high <= bus_i.wdata;
        QUGC_ADR_SAMPLING: sampling_rate_select <= {4'h0, bus_i.wdata[3:0]};
        default:           ;
      endcase
    end
  end

  assign sampling_8x_o = sampling_rate_select[3:0];

  // Soft reset bits last one cycle per write; every cycle without a reset write clears them
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      channel_soft_reset_o <= '0;
    else if (wr_hit && (bus_i.addr == QUGC_ADR_CH_RESET))
      channel_soft_reset_o <= bus_i.wdata[3:0];
    else
      channel_soft_reset_o <= '0;
  end

  // Two-flop synchroniser for the external count clock
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_prev  <= 1'b0;
    end
    else
    begin
      ext_sync1 <= external_count_clock_pin_i;
      ext_sync2 <= ext_sync1;
      ext_prev  <= ext_sync2;
    end
  end

  // Internal source counts every device clock; external on its rising edge
  assign tick     = count_control[QUGC_CTL_EXT_CLK] ? (ext_sync2 && !ext_prev) : 1'b1;
  assign hit_zero = (tstate == QUGC_T_RUN) && tick && (count_value <= 16'h0001);

  // Counter state; a preset of zero or one times out on the next tick
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      tstate      <= QUGC_T_IDLE;
      count_value <= QUGC_RST_COUNT;
    end
    else if (start_write)
    begin
      tstate      <= QUGC_T_RUN;
      count_value <= {count_preset_high, count_preset_low};
    end
    else
    begin
      case (tstate)
        QUGC_T_IDLE:
          if (count_control[QUGC_CTL_START] && count_value != 16'h0000)
            tstate <= QUGC_T_RUN;
        QUGC_T_RUN:
          if (!count_control[QUGC_CTL_START])
            tstate <= QUGC_T_IDLE; // pause keeps the count
          else if (hit_zero)
          begin
            count_value <= {count_preset_high, count_preset_low};
            if (count_control[QUGC_CTL_ONESHOT])
            begin
              tstate      <= QUGC_T_IDLE;
              count_value <= QUGC_RST_COUNT;
            end
          end
          else if (tick)
            count_value <= count_value - 16'h0001;
        default:
          tstate <= QUGC_T_IDLE;
      endcase
    end
  end

  // Sticky time-out; a new time-out wins over a clearing read
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      timeout_flag <= 1'b0;
    else if (hit_zero && count_control[QUGC_CTL_START])
      timeout_flag <= 1'b1;
    else if (ctl_read)
      timeout_flag <= 1'b0;
  end

  assign count_timeout_o = timeout_flag;

  // Checks

  sequence s_ctl_read_quiet;
    ctl_read && !hit_zero;
  endsequence

  sequence s_soft_reset_write;
    wr_hit && (bus_i.addr == QUGC_ADR_CH_RESET) && (bus_i.wdata[3:0] != 4'h0);
  endsequence

  property p_pending_reserved;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_hit && bus_i.addr == QUGC_ADR_PENDING) |=> (rdata_o[7:4] == 4'h0);
  endproperty
  a_pending_reserved: assert property (p_pending_reserved) else $error("pending upper bits not zero");

  property p_pending_matches_code;
    @(posedge clk_i) disable iff (!reset_n_i)
      (chan_src_i[1] != 6'h00) |=> channel_pending_o[1];
  endproperty
  a_pending_matches_code: assert property (p_pending_matches_code) else $error("pending flag and code disagree");

  property p_rx_priority;
    @(posedge clk_i) disable iff (!reset_n_i)
      (chan_src_i[2].line_error && chan_src_i[2].rx_timeout) |=> (code[2] == QUGC_CODE_RX);
  endproperty
  a_rx_priority: assert property (p_rx_priority) else $error("line error not given code one");

  property p_tout_code;
    @(posedge clk_i) disable iff (!reset_n_i)
      (chan_src_i[3].rx_timeout && !chan_src_i[3].rx_data_available && !chan_src_i[3].line_error)
        |=> (code[3] == QUGC_CODE_RX_TOUT) && channel_pending_o[3];
  endproperty
  a_tout_code: assert property (p_tout_code) else $error("time-out code wrong");

  property p_timer_only_ch0;
    @(posedge clk_i) disable iff (!reset_n_i)
      (code[1] != QUGC_CODE_TIMER) && (code[3] < 3'h5) && (code[0] != 3'h5) && (code[0] != 3'h6);
  endproperty
  a_timer_only_ch0: assert property (p_timer_only_ch0) else $error("reserved source code seen");

  property p_ctl_read_clears;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_ctl_read_quiet |=> !timeout_flag ##1 (code[0] != QUGC_CODE_TIMER);
  endproperty
  a_ctl_read_clears: assert property (p_ctl_read_clears) else $error("control read left time-out set");

  property p_soft_reset_pulse;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_soft_reset_write ##1 !s_soft_reset_write |-> (channel_soft_reset_o != 4'h0) ##1 (channel_soft_reset_o == 4'h0);
  endproperty
  a_soft_reset_pulse: assert property (p_soft_reset_pulse) else $error("soft reset did not self-clear");

  property p_oneshot_stops;
    @(posedge clk_i) disable iff (!reset_n_i)
      (hit_zero && count_control[QUGC_CTL_ONESHOT] && count_control[QUGC_CTL_START] && !start_write)
        |=> (tstate == QUGC_T_IDLE) && timeout_flag;
  endproperty
  a_oneshot_stops: assert property (p_oneshot_stops) else $error("single shot kept running");

  property p_retrigger_reload;
    @(posedge clk_i) disable iff (!reset_n_i)
      (hit_zero && !count_control[QUGC_CTL_ONESHOT] && count_control[QUGC_CTL_START] && !start_write && !wr_hit)
        |=> (count_value == {count_preset_high, count_preset_low}) && (tstate == QUGC_T_RUN);
  endproperty
  a_retrigger_reload: assert property (p_retrigger_reload) else $error("re-trigger did not reload");

  property p_ctl_reserved;
    @(posedge clk_i) disable iff (!reset_n_i)
      wr_hit && (bus_i.addr == QUGC_ADR_CNT_CTL) |=> (count_control[7:4] == 4'h0);
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved) else $error("reserved control bits stored");

  property p_src_low_pack;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_hit && bus_i.addr == QUGC_ADR_SRC_LOW) |=> (rdata_o[2:0] == $past(code[0])) && rdata_valid_o;
  endproperty
  a_src_low_pack: assert property (p_src_low_pack) else $error("source low packing wrong");

  property p_spare_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_hit && (bus_i.addr == QUGC_ADR_AUX_SPR || bus_i.addr == QUGC_ADR_CNT_SPR)) |=> (rdata_o == 8'h00);
  endproperty
  a_spare_zero: assert property (p_spare_zero) else $error("reserved register not zero");

  // Flag must fall once the channel logic has cleared every source
  property p_pending_drops;
    @(posedge clk_i) disable iff (!reset_n_i)
      (chan_src_i[1] == 6'h00) |=> !channel_pending_o[1];
  endproperty
  a_pending_drops: assert property (p_pending_drops) else $error("pending flag stuck high");

  // Write-only reset location never echoes what was written
  property p_ch_reset_reads_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_hit && bus_i.addr == QUGC_ADR_CH_RESET) |=> (rdata_o == 8'h00);
  endproperty
  a_ch_reset_reads_zero: assert property (p_ch_reset_reads_zero) else $error("reset register read not zero");

  // Enabled time-out with a quiet channel 0 shows code seven
  property p_timer_code;
    @(posedge clk_i) disable iff (!reset_n_i)
      (timeout_flag && count_control[QUGC_CTL_INT_EN] && (chan_src_i[0] == 6'h00))
        |=> (code[0] == QUGC_CODE_TIMER);
  endproperty
  a_timer_code: assert property (p_timer_code) else $error("timer code seven missing");

  // Sampling select follows the written low nibble
  property p_sampling_write;
    @(posedge clk_i) disable iff (!reset_n_i)
      (wr_hit && bus_i.addr == QUGC_ADR_SAMPLING) |=> ({4'h0, sampling_8x_o} == ($past(bus_i.wdata) & 8'h0f));
  endproperty
  a_sampling_write: assert property (p_sampling_write) else $error("sampling select not stored");

  // Start write loads the full preset and runs
  property p_preset_load;
    @(posedge clk_i) disable iff (!reset_n_i)
      start_write |=> (tstate == QUGC_T_RUN) && (count_value[7:0] == $past(count_preset_low))
        && (count_value[15:8] == $past(count_preset_high));
  endproperty
  a_preset_load: assert property (p_preset_load) else $error("preset not loaded at start");

endmodule

//--- tb/qugc_host_model.sv
// Host processor model driving the 8-bit configuration bus.
// Assumes the bus is synchronous to clk_i; requests change 1 ns after an edge.
`timescale 1ns/1ns
module qugc_host_model
  import qugc_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Bus towards the device
  output qugc_bus_t       bus_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rdata_valid_i
);
  // Idle bus at time zero, nothing selected
  initial bus_o = '0;

  // One write; strobe held for exactly one sampling edge
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    #1;
    bus_o = '{sel: 1'b1, rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
    @(posedge clk_i);
    #1;
    bus_o = '{sel: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
  endtask

  // One read; answer registered at the taking edge, sampled just after it
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(posedge clk_i);
    #1;
    bus_o = '{sel: 1'b1, rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
    @(posedge clk_i);
    #1;
    bus_o = '{sel: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: 8'hff};
    data  = rdata_i;
    ok    = rdata_valid_i;
  endtask
endmodule

//--- tb/qugc_global_control_tb_top.sv
// Self-checking bench for the global control bank: register table rows,
// then soft reset, out-of-block, timer and mid-run reset cases by hand.
`timescale 1ns/1ns
module qugc_global_control_tb_top
  import qugc_pkg::*;
;
  typedef struct {
    logic [23:0] src;
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  exp;
  } qugc_row_t;

  // Ch3 err+char, ch2 tx, ch1 modem, ch0 timeout+tx; then ch3 timeout, ch2 rx+err+timeout
  localparam logic [23:0] SMIX = {6'h11, 6'h04, 6'h02, 6'h0c};
  localparam logic [23:0] SONE = {6'h08, 6'h38, 6'h00, 6'h00};

  logic                   clk;
  logic                   reset_n;
  logic                   ext_clk;
  qugc_src_t [3:0]        src;
  qugc_bus_t              bus;
  logic [7:0]             rdata;
  logic                   rvalid;
  logic [3:0]             pending;
  logic [3:0]             samp;
  logic [3:0]             soft_rst;
  logic                   tmo;
  logic [7:0]             rd;
  logic                   ok;
  int                     err_total = 0;
  int                     n_checks = 0;

  qugc_row_t rows [25] = '{
    '{24'h0, 1'b0, 8'h80, 8'h00, 8'h00}, '{24'h0, 1'b0, 8'h81, 8'h00, 8'h00},
    '{24'h0, 1'b0, 8'h82, 8'h00, 8'h00}, '{24'h0, 1'b0, 8'h83, 8'h00, 8'h00},
    '{24'h0, 1'b0, 8'h84, 8'h00, 8'h00}, '{24'h0, 1'b0, 8'h85, 8'h00, 8'h00},
    '{24'h0, 1'b0, 8'h86, 8'h00, 8'h00}, '{24'h0, 1'b0, 8'h87, 8'h00, 8'h00},
    '{24'h0, 1'b0, 8'h88, 8'h00, 8'h00}, '{24'h0, 1'b0, 8'h89, 8'h00, 8'h00},
    '{24'h0, 1'b0, 8'h8a, 8'h00, 8'h00}, '{24'h0, 1'b1, 8'h88, 8'hff, 8'h0f},
    '{24'h0, 1'b1, 8'h85, 8'hff, 8'h00}, '{24'h0, 1'b1, 8'h89, 8'hff, 8'h00},
    '{24'h0, 1'b1, 8'h83, 8'hff, 8'h00}, '{24'h0, 1'b1, 8'h80, 8'hff, 8'h00},
    '{24'h0, 1'b1, 8'h86, 8'ha5, 8'ha5}, '{24'h0, 1'b1, 8'h87, 8'h3c, 8'h3c},
    '{SMIX, 1'b0, 8'h80, 8'h00, 8'h0f}, '{SMIX, 1'b0, 8'h81, 8'h00, 8'he2},
    '{SMIX, 1'b0, 8'h82, 8'h00, 8'h02}, '{SONE, 1'b0, 8'h80, 8'h00, 8'h0c},
    '{SONE, 1'b0, 8'h81, 8'h00, 8'h40}, '{SONE, 1'b0, 8'h82, 8'h00, 8'h04},
    '{24'h0, 1'b0, 8'h80, 8'h00, 8'h00}
  };

  // Device under test and host partner
  qugc_global_control i_dut (
    .clk_i                      (clk),
    .reset_n_i                  (reset_n),
    .bus_i                      (bus),
    .rdata_o                    (rdata),
    .rdata_valid_o              (rvalid),
    .chan_src_i                 (src),
    .external_count_clock_pin_i (ext_clk),
    .channel_pending_o          (pending),
    .sampling_8x_o              (samp),
    .channel_soft_reset_o       (soft_rst),
    .count_timeout_o            (tmo)
  );

  qugc_host_model i_host (
    .clk_i         (clk),
    .bus_o         (bus),
    .rdata_i       (rdata),
    .rdata_valid_i (rvalid)
  );

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for the time-out flag; running out ends the run
  task automatic wait_lvl(input logic val, input int n);
    int k;
    for (k = 0; k < n && tmo !== val; k++)
    begin
      @(posedge clk);
      #1;
    end
    n_checks++;
    if (tmo !== val)
    begin
      err_total++;
      $display("FAIL %0t: time-out flag not %0b in time", $time, val);
      tally_and_finish();
    end
  endtask

  // Flag must stay clear for n cycles
  task automatic hold_low(input int n);
    repeat (n)
    begin
      chk({7'h0, tmo}, 8'h00);
      @(posedge clk);
      #1;
    end
  endtask

  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    ext_clk = 1'b0;
    src     = '0;
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    foreach (rows[i])
    begin
      src = rows[i].src;
      if (rows[i].wr)
        i_host.write_reg(rows[i].addr, rows[i].wdata);
      i_host.read_reg(rows[i].addr, rd, ok);
      chk({7'h0, ok}, 8'h01);
      chk(rd, rows[i].exp);
      if (rows[i].addr == QUGC_ADR_PENDING)
        chk({4'h0, pending}, rows[i].exp);
    end
    chk({4'h0, samp}, 8'h0f);
    // Soft reset pulses once, then drops
    i_host.write_reg(QUGC_ADR_CH_RESET, 8'h05);
    chk({4'h0, soft_rst}, 8'h05);
    @(posedge clk);
    #1;
    chk({4'h0, soft_rst}, 8'h00);
    i_host.read_reg(8'h40, rd, ok);
    chk({7'h0, ok}, 8'h00);
    // One-shot on internal clock, preset 5
    i_host.write_reg(QUGC_ADR_PRE_HIGH, 8'h00);
    i_host.write_reg(QUGC_ADR_PRE_LOW, 8'h05);
    i_host.write_reg(QUGC_ADR_CNT_CTL, 8'h07);
    hold_low(5);
    wait_lvl(1'b1, 0);
    i_host.read_reg(QUGC_ADR_SRC_LOW, rd, ok);
    chk(rd, 8'h07);
    i_host.read_reg(QUGC_ADR_CNT_CTL, rd, ok);
    chk(rd, 8'h07);
    wait_lvl(1'b0, 3);
    hold_low(20);
    i_host.read_reg(QUGC_ADR_PENDING, rd, ok);
    chk(rd, 8'h00);
    // Re-trigger reloads and times out again
    i_host.write_reg(QUGC_ADR_CNT_CTL, 8'h03);
    wait_lvl(1'b1, 10);
    i_host.read_reg(QUGC_ADR_CNT_CTL, rd, ok);
    chk(rd, 8'h03);
    wait_lvl(1'b0, 3);
    wait_lvl(1'b1, 10);
    // Pause holds the count
    i_host.write_reg(QUGC_ADR_CNT_CTL, 8'h01);
    i_host.read_reg(QUGC_ADR_CNT_CTL, rd, ok);
    chk(rd, 8'h01);
    wait_lvl(1'b0, 3);
    hold_low(20);
    // Interrupt disabled: flag sets but no code seven
    i_host.write_reg(QUGC_ADR_CNT_CTL, 8'h06);
    wait_lvl(1'b1, 10);
    i_host.read_reg(QUGC_ADR_SRC_LOW, rd, ok);
    chk(rd, 8'h00);
    i_host.read_reg(QUGC_ADR_CNT_CTL, rd, ok);
    chk(rd, 8'h06);
    wait_lvl(1'b0, 3);
    // External pin clock: nothing without edges, time-out after five
    i_host.write_reg(QUGC_ADR_CNT_CTL, 8'h0f);
    hold_low(20);
    repeat (5)
    begin
      ext_clk = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      ext_clk = 1'b0;
      repeat (4) @(posedge clk);
      #1;
    end
    wait_lvl(1'b1, 20);
    // Reset in mid-run restores defaults
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk({3'h0, tmo, samp}, 8'h00);
    i_host.read_reg(QUGC_ADR_PRE_LOW, rd, ok);
    chk(rd, 8'h00);
    tally_and_finish();
  end
endmodule
